// ==== pkg/tmc_defs.vh ====
// Purpose: Constants for the timer mode and control field block
// Assumes: Register offsets are byte addresses on a 32-bit register port
// Notes: Reserved bits read as zero
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

`define TMC_ADDR_W 12
`define TMC_OFF_CFG 12'h000
`define TMC_OFF_AMODE 12'h004
`define TMC_OFF_BMODE 12'h008
`define TMC_OFF_CTL 12'h00c

`define TMC_CFG_MSB 2
`define TMC_MODE_MSB 3
`define TMC_MODE_FLD_MSB 1
`define TMC_CFG_32 3'h0
`define TMC_CFG_RTC 3'h1
`define TMC_CFG_16_BIT 2

`define TMC_MODE_RSVD 2'h0
`define TMC_MODE_ONESHOT 2'h1
`define TMC_MODE_PERIODIC 2'h2
`define TMC_MODE_CAPTURE 2'h3

`define TMC_EDGE_RISE 2'h0
`define TMC_EDGE_FALL 2'h1
`define TMC_EDGE_RSVD 2'h2
`define TMC_EDGE_BOTH 2'h3

`define TMC_CTL_MSB 11
`define TMC_CTL_EV_HI 11
`define TMC_CTL_EV_LO 10
`define TMC_CTL_STALL 9
`define TMC_CTL_BEN 8
`define TMC_CTL_PWMINV 6
`define TMC_CTL_TRIGEN 5
// Writable bits of the control register
`define TMC_CTL_MASK 12'hf60

`endif

// ==== src/tmc_mode_decode.v ====
// Purpose: Decode a two-bit sub-timer mode field into one-hot mode flags
// Assumes: Field and valid come from registered state on the same clock
// Notes: Reserved code yields no mode
`include "tmc_defs.vh"

module tmc_mode_decode (
  input wire [`TMC_MODE_FLD_MSB:0] mode_i,
  input wire valid_i,
  output wire oneshot_o,
  output wire periodic_o,
  output wire capture_o
);

  // RQ2: mode code decode
  assign oneshot_o = valid_i & (mode_i == `TMC_MODE_ONESHOT);
  assign periodic_o = valid_i & (mode_i == `TMC_MODE_PERIODIC);
  assign capture_o = valid_i & (mode_i == `TMC_MODE_CAPTURE);

endmodule // tmc_mode_decode

// ==== src/tmc_ctrl.v ====
// Purpose: Configuration, mode and control fields of a dual sub-timer
// Assumes: Register port on clock_i; debug halt and pwm/trigger pins from outside
// Notes: Counters themselves live elsewhere; this block steers them
//
// How it works
// RQ1: 32-bit pair ignores second mode register
// RQ2: Mode codes one-shot, periodic, capture
// RQ3: 16-bit uses second timer's own mode
// RQ4: Mode read per global width config
// RQ5: Capture edge select in bits 11:10
// RQ6: Stall bit freezes counting when halted
// RQ7: Stall ignored while running normally
// RQ8: Bit 8 enables second sub-timer
// RQ9: Bit 6 inverts first PWM output
// RQ10: Bit 5 gates converter trigger
// RQ11: Trigger offered as converter start source
// RQ12: Config 0 is 32-bit, 4-7 dual 16-bit
// RQ13: Halt input only gates stalled counting
//
// Strobed register access was decided locally.
`include "tmc_defs.vh"

module tmc_ctrl (
  input wire clock_i,
  input wire rstn_i,
  input wire [`TMC_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire debug_halt_i,
  input wire first_pwm_i,
  input wire first_trigger_i,
  input wire second_capture_pin_i,
  output reg first_pwm_o,
  output reg converter_start_o,
  output reg second_count_en_o,
  output reg second_capture_en_o,
  output reg second_capture_event_o,
  output reg second_oneshot_o,
  output reg second_periodic_o,
  output reg pair_32bit_o
);

  // Pin count of the synchroniser vector and register select lines
  localparam PIN_N = 4;
  localparam SEL_CFG = 0;
  localparam SEL_AMODE = 1;
  localparam SEL_BMODE = 2;
  localparam SEL_CTL = 3;

  // Stored register words and their next values
  reg [`TMC_CFG_MSB:0] global_width_config_q;
  reg [`TMC_MODE_MSB:0] first_timer_mode_q;
  reg [`TMC_MODE_MSB:0] second_timer_mode_q;
  reg [`TMC_CTL_MSB:0] timer_control_q;
  reg [`TMC_CFG_MSB:0] global_width_config_d;
  reg [`TMC_MODE_MSB:0] first_timer_mode_d;
  reg [`TMC_MODE_MSB:0] second_timer_mode_d;
  reg [`TMC_CTL_MSB:0] timer_control_d;
  reg [31:0] rdata_d;

  // Capture pin history for edge detection
  reg cap_prev_q;

  // Next values of the registered outputs
  reg first_pwm_d;
  reg converter_start_d;
  reg second_count_en_d;
  reg second_capture_en_d;
  reg second_capture_event_d;
  reg second_oneshot_d;
  reg second_periodic_d;
  reg pair_32bit_d;

  wire [PIN_N-1:0] pin_raw;
  wire [PIN_N-1:0] pin_sync;
  wire halt_sync;
  wire pwm_sync;
  wire trig_sync;
  wire cap_sync;
  wire [3:0] sel;
  wire halted;
  wire is32;
  wire is16;
  wire [`TMC_MODE_FLD_MSB:0] second_timer_mode_field;
  wire [`TMC_MODE_FLD_MSB:0] eff_mode;
  wire eff_valid;
  wire dec_oneshot;
  wire dec_periodic;
  wire dec_capture;
  wire [1:0] second_capture_edge_select;
  wire second_debug_stall;
  wire second_timer_enable;
  wire first_pwm_invert;
  wire first_converter_trigger_enable;
  wire b_enable;
  wire b_run;
  wire rise;
  wire fall;
  wire edge_hit;

  // Address decode shared by the write and read paths
  function [3:0] reg_select;
    input [`TMC_ADDR_W-1:0] addr;
    begin
      case (addr)
        `TMC_OFF_CFG: reg_select = 4'h1;
        `TMC_OFF_AMODE: reg_select = 4'h2;
        `TMC_OFF_BMODE: reg_select = 4'h4;
        `TMC_OFF_CTL: reg_select = 4'h8;
        default: reg_select = 4'h0;
      endcase
    end
  endfunction

  // RQ12: 32-bit pair decode
  function cfg_is_pair32;
    input [`TMC_CFG_MSB:0] cfg;
    begin
      cfg_is_pair32 = (cfg == `TMC_CFG_32);
    end
  endfunction

  // RQ12: split 16-bit decode
  function cfg_is_split16;
    input [`TMC_CFG_MSB:0] cfg;
    begin
      cfg_is_split16 = cfg[`TMC_CFG_16_BIT];
    end
  endfunction

  // RQ5: edge select decode
  function edge_pick;
    input [1:0] mode;
    input rise_seen;
    input fall_seen;
    begin
      case (mode)
        `TMC_EDGE_RISE: edge_pick = rise_seen;
        `TMC_EDGE_FALL: edge_pick = fall_seen;
        `TMC_EDGE_BOTH: edge_pick = rise_seen | fall_seen;
        default: edge_pick = 1'b0;
      endcase
    end
  endfunction

  assign sel = reg_select(addr_i);

  // Next register words: a write replaces the masked field
  always @* begin
    global_width_config_d = global_width_config_q;
    first_timer_mode_d = first_timer_mode_q;
    second_timer_mode_d = second_timer_mode_q;
    timer_control_d = timer_control_q;
    if (wr_i) begin
      if (sel[SEL_CFG]) begin
        global_width_config_d = wdata_i[`TMC_CFG_MSB:0];
      end
      if (sel[SEL_AMODE]) begin
        first_timer_mode_d = wdata_i[`TMC_MODE_MSB:0];
      end
      if (sel[SEL_BMODE]) begin
        second_timer_mode_d = wdata_i[`TMC_MODE_MSB:0];
      end
      if (sel[SEL_CTL]) begin
        timer_control_d = wdata_i[`TMC_CTL_MSB:0] & `TMC_CTL_MASK;
      end
    end
  end

  // Register write path
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      global_width_config_q <= `TMC_CFG_32;
      first_timer_mode_q <= {(`TMC_MODE_MSB+1){1'b0}};
      second_timer_mode_q <= {(`TMC_MODE_MSB+1){1'b0}};
      timer_control_q <= {(`TMC_CTL_MSB+1){1'b0}};
    end else begin
      global_width_config_q <= global_width_config_d;
      first_timer_mode_q <= first_timer_mode_d;
      second_timer_mode_q <= second_timer_mode_d;
      timer_control_q <= timer_control_d;
    end
  end

  // Read data for the cycle after the strobe; unmapped and idle read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (rd_i) begin
      if (sel[SEL_CFG]) begin
        rdata_d = {29'h0, global_width_config_q};
      end
      if (sel[SEL_AMODE]) begin
        rdata_d = {28'h0, first_timer_mode_q};
      end
      if (sel[SEL_BMODE]) begin
        rdata_d = {28'h0, second_timer_mode_q};
      end
      if (sel[SEL_CTL]) begin
        rdata_d = {20'h0, timer_control_q};
      end
    end
  end

  always @(posedge clock_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // Two flip-flops per pin before any logic sees it
  assign pin_raw = {second_capture_pin_i, first_trigger_i, first_pwm_i, debug_halt_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      always @(posedge clock_i) begin
        if (!rstn_i) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pin_raw[gi];
          sync_q <= meta_q;
        end
      end
      assign pin_sync[gi] = sync_q;
    end
  endgenerate

  assign {cap_sync, trig_sync, pwm_sync, halt_sync} = pin_sync;
  assign halted = halt_sync;

  // Previous capture level, reset to the idle level of the pin
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      cap_prev_q <= 1'b0;
    end else begin
      cap_prev_q <= cap_sync;
    end
  end

  // Named control fields
  assign second_timer_mode_field = second_timer_mode_q[`TMC_MODE_FLD_MSB:0];
  assign second_capture_edge_select = timer_control_q[`TMC_CTL_EV_HI:`TMC_CTL_EV_LO];
  assign second_debug_stall = timer_control_q[`TMC_CTL_STALL];
  assign second_timer_enable = timer_control_q[`TMC_CTL_BEN];
  assign first_pwm_invert = timer_control_q[`TMC_CTL_PWMINV];
  assign first_converter_trigger_enable = timer_control_q[`TMC_CTL_TRIGEN];

  // RQ12: width config decode
  assign is32 = cfg_is_pair32(global_width_config_q);
  assign is16 = cfg_is_split16(global_width_config_q);

  // RQ4: mode per config
  // RQ1: 32-bit uses first mode
  // RQ3: 16-bit own mode
  assign eff_mode = is32 ? first_timer_mode_q[`TMC_MODE_FLD_MSB:0] : second_timer_mode_field;
  // Configs other than 32-bit and split 16-bit leave no valid mode
  assign eff_valid = is32 | is16;

  tmc_mode_decode u_dec (
    .mode_i(eff_mode),
    .valid_i(eff_valid),
    .oneshot_o(dec_oneshot),
    .periodic_o(dec_periodic),
    .capture_o(dec_capture)
  );

  // RQ8: second timer enable
  assign b_enable = second_timer_enable & eff_valid;

  // RQ6: stall when halted
  // RQ7: ignored when running
  // RQ13: halt gates only
  assign b_run = b_enable & ~(second_debug_stall & halted);

  // RQ5: capture edge select
  assign rise = cap_sync & ~cap_prev_q;
  assign fall = ~cap_sync & cap_prev_q;
  assign edge_hit = edge_pick(second_capture_edge_select, rise, fall);

  // Next values of the outputs
  always @* begin
    // RQ9: pwm invert
    first_pwm_d = pwm_sync ^ first_pwm_invert;
    // RQ10: trigger gate
    // RQ11: converter start source
    converter_start_d = trig_sync & first_converter_trigger_enable;
    second_count_en_d = b_run & (dec_oneshot | dec_periodic);
    second_capture_en_d = b_run & dec_capture;
    second_capture_event_d = b_run & dec_capture & edge_hit;
    second_oneshot_d = dec_oneshot;
    second_periodic_d = dec_periodic;
    pair_32bit_d = is32;
  end

  // Registered outputs
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      first_pwm_o <= 1'b0;
      converter_start_o <= 1'b0;
      second_count_en_o <= 1'b0;
      second_capture_en_o <= 1'b0;
      second_capture_event_o <= 1'b0;
      second_oneshot_o <= 1'b0;
      second_periodic_o <= 1'b0;
      pair_32bit_o <= 1'b1;
    end else begin
      first_pwm_o <= first_pwm_d;
      converter_start_o <= converter_start_d;
      second_count_en_o <= second_count_en_d;
      second_capture_en_o <= second_capture_en_d;
      second_capture_event_o <= second_capture_event_d;
      second_oneshot_o <= second_oneshot_d;
      second_periodic_o <= second_periodic_d;
      pair_32bit_o <= pair_32bit_d;
    end
  end

endmodule // tmc_ctrl

// ==== tb/tmc_ctrl_chk.sv ====
// Purpose: Port checks for the timer control block
// Assumes: Pins steady around reset
// Notes: Pin paths take 3 edges
module tmc_chk (
  input wire clock_i,
  input wire rstn_i,
  input wire wr_i,
  input wire debug_halt_i,
  input wire first_pwm_i,
  input wire first_trigger_i,
  input wire first_pwm_o,
  input wire converter_start_o,
  input wire second_count_en_o,
  input wire second_capture_en_o,
  input wire second_oneshot_o,
  input wire second_periodic_o,
  input wire pair_32bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_quiet; (!debug_halt_i && !wr_i) [*4]; endsequence
  property p_excl; !(second_oneshot_o && second_periodic_o); endproperty
  a_excl: assert property (p_excl) else $error("two modes at once");
  property p_cnt; second_count_en_o |-> second_oneshot_o || second_periodic_o; endproperty
  a_cnt: assert property (p_cnt) else $error("count without mode");
  property p_cap; second_capture_en_o |-> !(second_count_en_o || second_periodic_o); endproperty
  a_cap: assert property (p_cap) else $error("capture beside count");
  property p_trig; converter_start_o |-> $past(first_trigger_i, 3); endproperty
  a_trig: assert property (p_trig) else $error("trigger without source");
  property p_pwm; $changed(first_pwm_i) ##1 !wr_i |-> ##2 $changed(first_pwm_o); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm edge lost");
  property p_pair; $changed(pair_32bit_o) |-> $past(wr_i, 2); endproperty
  a_pair: assert property (p_pair) else $error("width changed unasked");
  property p_run; s_quiet ##0 second_count_en_o |=> second_count_en_o; endproperty
  a_run: assert property (p_run) else $error("count stopped while running");
  property p_stop; $fell(second_count_en_o) |-> $past(debug_halt_i, 3) || $past(wr_i, 2); endproperty
  a_stop: assert property (p_stop) else $error("count stopped without cause");
endmodule // tmc_chk
bind tmc_ctrl tmc_chk tmc_chk_inst (.clock_i(clock_i), .rstn_i(rstn_i), .wr_i(wr_i),
  .debug_halt_i(debug_halt_i), .first_pwm_i(first_pwm_i), .first_trigger_i(first_trigger_i),
  .first_pwm_o(first_pwm_o), .converter_start_o(converter_start_o),
  .second_count_en_o(second_count_en_o), .second_capture_en_o(second_capture_en_o),
  .second_oneshot_o(second_oneshot_o), .second_periodic_o(second_periodic_o),
  .pair_32bit_o(pair_32bit_o));

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the timer control block
// Assumes: Read data stand one cycle after the strobe
// Notes: Model keeps masked register words
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, debug_halt_i = 0;
  logic first_pwm_i = 0, first_trigger_i = 0, second_capture_pin_i = 0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  wire [31:0] rdata_o;
  wire first_pwm_o, converter_start_o, second_count_en_o, second_capture_en_o;
  wire second_capture_event_o, second_oneshot_o, second_periodic_o, pair_32bit_o;
  int mismatches = 0, comparisons = 0, pulses = 0, m;
  int mem[5] = '{0, 0, 0, 0, 0};
  int cl[4] = '{0, 1, 4, 7};
  int ev[4] = '{1, 1, 0, 2};
  tmc_ctrl tmc_ctrl_inst (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .debug_halt_i(debug_halt_i), .first_pwm_i(first_pwm_i), .first_trigger_i(first_trigger_i),
    .second_capture_pin_i(second_capture_pin_i), .first_pwm_o(first_pwm_o),
    .converter_start_o(converter_start_o), .second_count_en_o(second_count_en_o),
    .second_capture_en_o(second_capture_en_o), .second_capture_event_o(second_capture_event_o),
    .second_oneshot_o(second_oneshot_o), .second_periodic_o(second_periodic_o),
    .pair_32bit_o(pair_32bit_o));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (second_capture_event_o === 1'b1) pulses <= pulses + 1;
  end
  function int msk(int a);
    return a == 0 ? 32'h7 : (a == 4 || a == 8) ? 32'hf : a == 12 ? 32'hf60 : 32'h0;
  endfunction
  function logic [3:0] flags();
    int md;
    md = mem[0] == 0 ? mem[1] & 3 : mem[0] > 3 ? mem[2] & 3 : 0;
    m = mem[3][8] && !(mem[3][9] && debug_halt_i);
    return {md == 1, md == 2, m[0] && (md == 1 || md == 2), m[0] && md == 3};
  endfunction
  task chk(bit ok, string s);
    comparisons++;
    if (!ok) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask
  task wr(int a, int d);
    @(posedge clock_i);
    addr_i <= a[11:0];
    wdata_i <= d;
    wr_i <= 1;
    mem[a / 4] = d & msk(a);
    @(posedge clock_i);
    wr_i <= 0;
  endtask
  task rd(int a);
    @(posedge clock_i);
    addr_i <= a[11:0];
    rd_i <= 1;
    @(posedge clock_i);
    rd_i <= 0;
    #1 chk(rdata_o === 32'(mem[a / 4]), "read data");
  endtask
  task settle(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #50000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hf5d0bccb));
    repeat (3) @(posedge clock_i);
    rstn_i <= 1;
    #1 chk(pair_32bit_o === 1'b1 && rdata_o === 32'h0, "reset");
    for (int a = 0; a < 20; a += 4) rd(a);
    repeat (6) for (int a = 0; a < 20; a += 4) begin
      wr(a, $urandom);
      rd(a);
    end
    // Mode codes against width settings 0, 1, 4 and 7, halted half the time
    foreach (cl[i]) for (int k = 0; k < 8; k++) begin
      wr(0, cl[i]);
      wr(8, k);
      wr(4, 3 - k);
      wr(12, $urandom);
      debug_halt_i <= k[2];
      first_pwm_i <= 1'($urandom);
      first_trigger_i <= 1'($urandom);
      settle(6);
      chk({second_oneshot_o, second_periodic_o, second_count_en_o, second_capture_en_o}
        === flags(), "mode flags");
      chk(pair_32bit_o === (cl[i] == 0), "width");
      chk(first_pwm_o === (first_pwm_i ^ mem[3][6]), "pwm level");
      chk(converter_start_o === (first_trigger_i & mem[3][5]), "trigger");
    end
    wr(0, 4);
    wr(8, 3);
    debug_halt_i <= 0;
    for (int e = 0; e < 4; e++) begin
      wr(12, 32'h100 | e << 10);
      settle(6);
      pulses = 0;
      @(posedge clock_i) second_capture_pin_i <= 1;
      settle(8);
      @(posedge clock_i) second_capture_pin_i <= 0;
      settle(8);
      chk(pulses === ev[e], "capture edges");
    end
    tally_and_finish;
  end
endmodule // tb
